// ### shared/cab_exec_map.vh
// constants for the arithmetic, logic and branch execution unit:
// operation codes, status bit positions, register map and cycle counts.
// assumes inclusion by bare name from the design file.
`ifndef CAB_EXEC_MAP_VH
`define CAB_EXEC_MAP_VH

// ----------------------------------------------------------------------
// operation codes (cmdOp)
// ----------------------------------------------------------------------
`define CAB_OP_SUM                      6'h00
`define CAB_OP_SUM_CARRY                6'h01
`define CAB_OP_WORD_PAIR_PLUS_IMMEDIATE 6'h02
`define CAB_OP_DIFFERENCE               6'h03
`define CAB_OP_DIFFERENCE_WITH_CONSTANT 6'h04
`define CAB_OP_BORROW_DIFFERENCE        6'h05
`define CAB_OP_BORROW_DIFFERENCE_CONST  6'h06
`define CAB_OP_WORD_PAIR_MINUS_IMMEDIATE 6'h07
`define CAB_OP_CONJUNCTION              6'h08
`define CAB_OP_CONJUNCTION_WITH_CONST   6'h09
`define CAB_OP_DISJUNCTION              6'h0a
`define CAB_OP_DISJUNCTION_WITH_CONST   6'h0b
`define CAB_OP_EXCLUSIVE_DISJUNCTION    6'h0c
`define CAB_OP_ONES_INVERSE             6'h0d
`define CAB_OP_TWOS_INVERSE             6'h0e
`define CAB_OP_BIT_SET_BY_MASK          6'h0f
`define CAB_OP_BIT_CLEAR_BY_MASK        6'h10
`define CAB_OP_PLUS_ONE                 6'h11
`define CAB_OP_MINUS_ONE                6'h12
`define CAB_OP_ZERO_SIGN_CHECK          6'h13
`define CAB_OP_REGISTER_ZEROING         6'h14
`define CAB_OP_REGISTER_ALL_ONES        6'h15
`define CAB_OP_PRODUCT_UNSIGNED         6'h16
`define CAB_OP_PRODUCT_SIGNED           6'h17
`define CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED 6'h18
`define CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED 6'h19
`define CAB_OP_FRACTIONAL_PRODUCT_SIGNED 6'h1a
`define CAB_OP_FRACTIONAL_PRODUCT_MIXED 6'h1b
`define CAB_OP_RELATIVE_BRANCH          6'h1c
`define CAB_OP_POINTER_BRANCH           6'h1d
`define CAB_OP_ABSOLUTE_BRANCH          6'h1e
`define CAB_OP_RELATIVE_SUBROUTINE_ENTRY 6'h1f
`define CAB_OP_POINTER_SUBROUTINE_ENTRY 6'h20
`define CAB_OP_ABSOLUTE_SUBROUTINE_ENTRY 6'h21
`define CAB_OP_SUBROUTINE_EXIT          6'h22
`define CAB_OP_HANDLER_EXIT             6'h23
`define CAB_OP_SKIP_IF_EQUAL            6'h24
`define CAB_OP_REGISTER_COMPARISON      6'h25
`define CAB_OP_COMPARISON_WITH_BORROW   6'h26

// ----------------------------------------------------------------------
// status register bit positions and reset value
// ----------------------------------------------------------------------
`define CAB_SR_C 0
`define CAB_SR_Z 1
`define CAB_SR_N 2
`define CAB_SR_V 3
`define CAB_SR_S 4
`define CAB_SR_H 5
`define CAB_SR_T 6
`define CAB_SR_I 7
`define CAB_SR_RESET 8'h00

// ----------------------------------------------------------------------
// register map (plain register port)
// ----------------------------------------------------------------------
`define CAB_ADDR_GPR_LAST 6'h1f
`define CAB_ADDR_STATUS   6'h20
`define CAB_ADDR_PC_LOW   6'h21
`define CAB_ADDR_PC_HIGH  6'h22
`define CAB_ADDR_STACK    6'h23
`define CAB_PC_RESET      16'h0000

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define CAB_CYC_ONE   2'h1
`define CAB_CYC_TWO   2'h2
`define CAB_CYC_THREE 2'h3
`define CAB_CYC_FOUR  3'h4

`endif

// ### hw/cab_exec_unit.v
// execution unit of an 8-bit core: arithmetic, logic, multiply, compare
// and branch operations with register file, status, pc and return stack.
// assumes one clock, synchronous inputs, and a decoder that presents one
// operation per cmdValid pulse while busy is low.
`timescale 1ns/1ps
`include "cab_exec_map.vh"

module cab_exec_unit #(
  parameter LARGE_VARIANT = 1,
  parameter STACK_DEPTH = 16,
  parameter STACK_BITS = 4
) (
  input wire clk,
  input wire nrst,
  input wire cmdValid,
  input wire [5:0] cmdOp,
  input wire [4:0] cmdDst,
  input wire [4:0] cmdSrc,
  input wire [15:0] cmdK,
  input wire cmdNextTwoWords,
  input wire [5:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  output reg busy,
  output reg done,
  output reg illegal,
  output reg [15:0] pcOut,
  output reg globalIntEnable
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [7:0] gpr [0:31];
  reg [7:0] sreg;
  reg [15:0] pc;
  reg [15:0] stack [0:STACK_DEPTH-1];
  reg [STACK_BITS-1:0] sp;
  reg [2:0] remain;
  integer i;

  // ----------------------------------------------------------------------
  // flag helpers: returns {h, v, c}
  // ----------------------------------------------------------------------
  function [2:0] addHvc;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      addHvc[2] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      addHvc[1] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      addHvc[0] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    end
  endfunction

  function [2:0] subHvc;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      subHvc[2] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      subHvc[1] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      subHvc[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // operation decode and result
  // ----------------------------------------------------------------------
  reg [7:0] opA;
  reg [7:0] opB;
  reg [7:0] res;
  reg [15:0] wide;
  reg [2:0] hvc;
  reg [7:0] next_sreg;
  reg [15:0] next_pc;
  reg [2:0] cycles;
  reg wrDst;
  reg wrPair;
  reg wrProd;
  reg doPush;
  reg doPop;
  reg [15:0] pushVal;
  reg badOp;
  reg sgnA;
  reg sgnB;
  reg frac;
  reg [31:0] prod;
  reg [15:0] prod16;

  wire accept = cmdValid & ~busy;
  wire [15:0] pair = {gpr[{cmdDst[4:1], 1'b1}], gpr[{cmdDst[4:1], 1'b0}]};
  wire [15:0] ptr = {gpr[31], gpr[30]};
  wire [15:0] relK = {{4{cmdK[11]}}, cmdK[11:0]};
  wire [15:0] pcStep = pc + 16'h0001;

  always @* begin
    opA = gpr[cmdDst];
    opB = gpr[cmdSrc];
    res = 8'h00;
    wide = 16'h0000;
    hvc = 3'h0;
    next_sreg = sreg;
    next_pc = pcStep;
    cycles = {1'b0, `CAB_CYC_ONE};
    wrDst = 1'b0;
    wrPair = 1'b0;
    wrProd = 1'b0;
    doPush = 1'b0;
    doPop = 1'b0;
    pushVal = pcStep;
    badOp = 1'b0;
    sgnA = 1'b0;
    sgnB = 1'b0;
    frac = 1'b0;
    case (cmdOp)
      `CAB_OP_DIFFERENCE_WITH_CONSTANT, `CAB_OP_BORROW_DIFFERENCE_CONST,
      `CAB_OP_CONJUNCTION_WITH_CONST, `CAB_OP_DISJUNCTION_WITH_CONST,
      `CAB_OP_BIT_SET_BY_MASK, `CAB_OP_BIT_CLEAR_BY_MASK: begin
        opB = cmdK[7:0];
      end
    endcase
    case (cmdOp)
      `CAB_OP_SUM, `CAB_OP_SUM_CARRY: begin
        res = opA + opB + {7'h00, sreg[`CAB_SR_C] &
          (cmdOp == `CAB_OP_SUM_CARRY)};
        hvc = addHvc(opA, opB, res);
        wrDst = 1'b1;
      end
      `CAB_OP_DIFFERENCE, `CAB_OP_DIFFERENCE_WITH_CONSTANT,
      `CAB_OP_REGISTER_COMPARISON: begin
        res = opA - opB;
        hvc = subHvc(opA, opB, res);
        wrDst = (cmdOp != `CAB_OP_REGISTER_COMPARISON);
      end
      `CAB_OP_BORROW_DIFFERENCE, `CAB_OP_BORROW_DIFFERENCE_CONST,
      `CAB_OP_COMPARISON_WITH_BORROW: begin
        res = opA - opB - {7'h00, sreg[`CAB_SR_C]};
        hvc = subHvc(opA, opB, res);
        wrDst = (cmdOp != `CAB_OP_COMPARISON_WITH_BORROW);
      end
      `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE: begin
        wide = pair + {10'h000, cmdK[5:0]};
        wrPair = 1'b1;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_WORD_PAIR_MINUS_IMMEDIATE: begin
        wide = pair - {10'h000, cmdK[5:0]};
        wrPair = 1'b1;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_CONJUNCTION, `CAB_OP_CONJUNCTION_WITH_CONST,
      `CAB_OP_ZERO_SIGN_CHECK: begin
        res = (cmdOp == `CAB_OP_ZERO_SIGN_CHECK) ? opA : opA & opB;
        wrDst = 1'b1;
      end
      `CAB_OP_DISJUNCTION, `CAB_OP_DISJUNCTION_WITH_CONST,
      `CAB_OP_BIT_SET_BY_MASK: begin
        res = opA | opB;
        wrDst = 1'b1;
      end
      `CAB_OP_BIT_CLEAR_BY_MASK: begin
        res = opA & (8'hff - opB);
        wrDst = 1'b1;
      end
      `CAB_OP_EXCLUSIVE_DISJUNCTION, `CAB_OP_REGISTER_ZEROING: begin
        res = (cmdOp == `CAB_OP_REGISTER_ZEROING) ? 8'h00 : opA ^ opB;
        wrDst = 1'b1;
      end
      `CAB_OP_ONES_INVERSE: begin
        res = 8'hff - opA;
        wrDst = 1'b1;
      end
      `CAB_OP_TWOS_INVERSE: begin
        res = 8'h00 - opA;
        hvc = {res[3] | opA[3], res == 8'h80, res != 8'h00};
        wrDst = 1'b1;
      end
      `CAB_OP_PLUS_ONE: begin
        res = opA + 8'h01;
        wrDst = 1'b1;
      end
      `CAB_OP_MINUS_ONE: begin
        res = opA - 8'h01;
        wrDst = 1'b1;
      end
      `CAB_OP_REGISTER_ALL_ONES: begin
        res = 8'hff;
        wrDst = 1'b1;
      end
      `CAB_OP_PRODUCT_UNSIGNED, `CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED: begin
        frac = (cmdOp == `CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED);
        wrProd = 1'b1;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_PRODUCT_SIGNED, `CAB_OP_FRACTIONAL_PRODUCT_SIGNED: begin
        sgnA = 1'b1;
        sgnB = 1'b1;
        frac = (cmdOp == `CAB_OP_FRACTIONAL_PRODUCT_SIGNED);
        wrProd = 1'b1;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED,
      `CAB_OP_FRACTIONAL_PRODUCT_MIXED: begin
        sgnA = 1'b1;
        frac = (cmdOp == `CAB_OP_FRACTIONAL_PRODUCT_MIXED);
        wrProd = 1'b1;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_RELATIVE_BRANCH: begin
        next_pc = pc + relK + 16'h0001;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_RELATIVE_SUBROUTINE_ENTRY: begin
        next_pc = pc + relK + 16'h0001;
        doPush = 1'b1;
        cycles = {1'b0, `CAB_CYC_THREE};
      end
      `CAB_OP_POINTER_BRANCH: begin
        next_pc = ptr;
        cycles = {1'b0, `CAB_CYC_TWO};
      end
      `CAB_OP_POINTER_SUBROUTINE_ENTRY: begin
        next_pc = ptr;
        doPush = 1'b1;
        cycles = {1'b0, `CAB_CYC_THREE};
      end
      `CAB_OP_ABSOLUTE_BRANCH, `CAB_OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
        if (LARGE_VARIANT != 0) begin
          next_pc = cmdK;
          doPush = (cmdOp == `CAB_OP_ABSOLUTE_SUBROUTINE_ENTRY);
          pushVal = pc + 16'h0002;
          cycles = doPush ? `CAB_CYC_FOUR : {1'b0, `CAB_CYC_THREE};
        end else begin
          badOp = 1'b1;
        end
      end
      `CAB_OP_SUBROUTINE_EXIT, `CAB_OP_HANDLER_EXIT: begin
        next_pc = stack[sp - {{(STACK_BITS-1){1'b0}}, 1'b1}];
        doPop = 1'b1;
        cycles = `CAB_CYC_FOUR;
        if (cmdOp == `CAB_OP_HANDLER_EXIT) begin
          next_sreg[`CAB_SR_I] = 1'b1;
        end
      end
      `CAB_OP_SKIP_IF_EQUAL: begin
        if (opA == opB) begin
          next_pc = pc + (cmdNextTwoWords ? 16'h0003 : 16'h0002);
          cycles = cmdNextTwoWords ? {1'b0, `CAB_CYC_THREE} :
            {1'b0, `CAB_CYC_TWO};
        end
      end
      default: begin
        badOp = 1'b1;
      end
    endcase

    // multiplier
    prod = {{8{sgnA & opA[7]}}, opA} * {{8{sgnB & opB[7]}}, opB};
    prod16 = frac ? {prod[14:0], 1'b0} : prod[15:0];

    // flag update per group
    case (cmdOp)
      `CAB_OP_SUM, `CAB_OP_SUM_CARRY, `CAB_OP_DIFFERENCE,
      `CAB_OP_DIFFERENCE_WITH_CONSTANT, `CAB_OP_REGISTER_COMPARISON,
      `CAB_OP_TWOS_INVERSE: begin
        next_sreg[`CAB_SR_H] = hvc[2];
        next_sreg[`CAB_SR_V] = hvc[1];
        next_sreg[`CAB_SR_C] = hvc[0];
        next_sreg[`CAB_SR_N] = res[7];
        next_sreg[`CAB_SR_Z] = (res == 8'h00);
      end
      `CAB_OP_BORROW_DIFFERENCE, `CAB_OP_BORROW_DIFFERENCE_CONST,
      `CAB_OP_COMPARISON_WITH_BORROW: begin
        next_sreg[`CAB_SR_H] = hvc[2];
        next_sreg[`CAB_SR_V] = hvc[1];
        next_sreg[`CAB_SR_C] = hvc[0];
        next_sreg[`CAB_SR_N] = res[7];
        next_sreg[`CAB_SR_Z] = (res == 8'h00) & sreg[`CAB_SR_Z];
      end
      `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE, `CAB_OP_WORD_PAIR_MINUS_IMMEDIATE:
      begin
        next_sreg[`CAB_SR_N] = wide[15];
        next_sreg[`CAB_SR_Z] = (wide == 16'h0000);
        if (cmdOp == `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE) begin
          next_sreg[`CAB_SR_V] = ~pair[15] & wide[15];
          next_sreg[`CAB_SR_C] = ~wide[15] & pair[15];
        end else begin
          next_sreg[`CAB_SR_V] = pair[15] & ~wide[15];
          next_sreg[`CAB_SR_C] = wide[15] & ~pair[15];
        end
      end
      `CAB_OP_ONES_INVERSE: begin
        next_sreg[`CAB_SR_C] = 1'b1;
        next_sreg[`CAB_SR_V] = 1'b0;
        next_sreg[`CAB_SR_N] = res[7];
        next_sreg[`CAB_SR_Z] = (res == 8'h00);
      end
      `CAB_OP_PLUS_ONE, `CAB_OP_MINUS_ONE: begin
        next_sreg[`CAB_SR_V] = (cmdOp == `CAB_OP_PLUS_ONE) ?
          (res == 8'h80) : (res == 8'h7f);
        next_sreg[`CAB_SR_N] = res[7];
        next_sreg[`CAB_SR_Z] = (res == 8'h00);
      end
      `CAB_OP_CONJUNCTION, `CAB_OP_CONJUNCTION_WITH_CONST,
      `CAB_OP_ZERO_SIGN_CHECK, `CAB_OP_DISJUNCTION,
      `CAB_OP_DISJUNCTION_WITH_CONST, `CAB_OP_BIT_SET_BY_MASK,
      `CAB_OP_BIT_CLEAR_BY_MASK, `CAB_OP_EXCLUSIVE_DISJUNCTION,
      `CAB_OP_REGISTER_ZEROING: begin
        next_sreg[`CAB_SR_V] = 1'b0;
        next_sreg[`CAB_SR_N] = res[7];
        next_sreg[`CAB_SR_Z] = (res == 8'h00);
      end
      `CAB_OP_PRODUCT_UNSIGNED, `CAB_OP_PRODUCT_SIGNED,
      `CAB_OP_PRODUCT_SIGNED_BY_UNSIGNED,
      `CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED,
      `CAB_OP_FRACTIONAL_PRODUCT_SIGNED, `CAB_OP_FRACTIONAL_PRODUCT_MIXED:
      begin
        next_sreg[`CAB_SR_C] = prod[15];
        next_sreg[`CAB_SR_Z] = (prod16 == 16'h0000);
      end
      default: begin
      end
    endcase
    if (cmdOp <= `CAB_OP_REGISTER_ZEROING ||
        cmdOp >= `CAB_OP_REGISTER_COMPARISON) begin
      next_sreg[`CAB_SR_S] = next_sreg[`CAB_SR_N] ^ next_sreg[`CAB_SR_V];
    end
    if (badOp) begin
      next_sreg = sreg;
      next_pc = pc;
      cycles = {1'b0, `CAB_CYC_ONE};
    end
  end

  // ----------------------------------------------------------------------
  // register file, status, pc and stack
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr[i] <= 8'h00;
      end
      sreg <= `CAB_SR_RESET;
      pc <= `CAB_PC_RESET;
      sp <= {STACK_BITS{1'b0}};
    end else begin
      if (regWr && regAddr <= `CAB_ADDR_GPR_LAST) begin
        gpr[regAddr[4:0]] <= regWrData;
      end
      if (accept) begin
        if (wrDst) begin
          gpr[cmdDst] <= res;
        end
        if (wrPair) begin
          gpr[{cmdDst[4:1], 1'b0}] <= wide[7:0];
          gpr[{cmdDst[4:1], 1'b1}] <= wide[15:8];
        end
        if (wrProd) begin
          gpr[0] <= prod16[7:0];
          gpr[1] <= prod16[15:8];
        end
        sreg <= next_sreg;
        pc <= next_pc;
        if (doPush) begin
          stack[sp] <= pushVal;
          sp <= sp + {{(STACK_BITS-1){1'b0}}, 1'b1};
        end else if (doPop) begin
          sp <= sp - {{(STACK_BITS-1){1'b0}}, 1'b1};
        end
      end else if (regWr && !busy) begin
        if (regAddr == `CAB_ADDR_STATUS) begin
          sreg <= regWrData;
        end else if (regAddr == `CAB_ADDR_PC_LOW) begin
          pc[7:0] <= regWrData;
        end else if (regAddr == `CAB_ADDR_PC_HIGH) begin
          pc[15:8] <= regWrData;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // cycle timing and outputs
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      pcOut <= `CAB_PC_RESET;
      globalIntEnable <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      illegal <= accept & badOp;
      if (accept) begin
        remain <= cycles - 3'h1;
        busy <= (cycles != 3'h1);
        done <= (cycles == 3'h1);
      end else if (busy) begin
        remain <= remain - 3'h1;
        busy <= (remain != 3'h1);
        done <= (remain == 3'h1);
      end else begin
        done <= 1'b0;
      end
      pcOut <= accept ? next_pc : pc;
      globalIntEnable <= accept ? next_sreg[`CAB_SR_I] : sreg[`CAB_SR_I];
      if (regRd) begin
        if (regAddr <= `CAB_ADDR_GPR_LAST) begin
          regRdData <= gpr[regAddr[4:0]];
        end else if (regAddr == `CAB_ADDR_STATUS) begin
          regRdData <= sreg;
        end else if (regAddr == `CAB_ADDR_PC_LOW) begin
          regRdData <= pc[7:0];
        end else if (regAddr == `CAB_ADDR_PC_HIGH) begin
          regRdData <= pc[15:8];
        end else if (regAddr == `CAB_ADDR_STACK) begin
          regRdData <= {{(8-STACK_BITS){1'b0}}, sp};
        end else begin
          regRdData <= 8'h00;
        end
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

endmodule // cab_exec_unit

// ### test/cab_exec_unit_checker.sv
// assertion checker for the execution unit
// assumes binding to cab_exec_unit; sees only its ports
`timescale 1ns/1ps
`include "cab_exec_map.vh"
// ----
// timing, pc and interrupt-enable checks
// ----
module cab_exec_unit_checker #(
  parameter LARGE_VARIANT = 1
) (
  input wire clk,
  input wire nrst,
  input wire cmdValid,
  input wire [5:0] cmdOp,
  input wire [15:0] cmdK,
  input wire busy,
  input wire done,
  input wire [15:0] pcOut,
  input wire globalIntEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire take = cmdValid && !busy;
  reg [15:0] relTarget;
  reg [15:0] absTarget;
  // targets as seen at the taking edge
  always @(posedge clk) begin
    relTarget <= pcOut + {{4{cmdK[11]}}, cmdK[11:0]} + 16'h0001;
    absTarget <= cmdK;
  end
  property p_arith;
    take && (cmdOp <= `CAB_OP_SUM_CARRY ||
    (cmdOp >= `CAB_OP_DIFFERENCE &&
    cmdOp <= `CAB_OP_BORROW_DIFFERENCE_CONST)) |=> done && !busy;
  endproperty
  a_arith: assert property (p_arith) else $error("arith not 1 cycle");
  property p_logic;
    take && cmdOp >= `CAB_OP_CONJUNCTION &&
    cmdOp <= `CAB_OP_REGISTER_ALL_ONES |=> done && !busy;
  endproperty
  a_logic: assert property (p_logic) else $error("logic not 1 cycle");
  property p_pair;
    take && (cmdOp == `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE ||
    cmdOp == `CAB_OP_WORD_PAIR_MINUS_IMMEDIATE)
    |=> busy && !done ##1 done && !busy;
  endproperty
  a_pair: assert property (p_pair) else $error("pair op not 2 cycles");
  property p_mul;
    take && cmdOp >= `CAB_OP_PRODUCT_UNSIGNED &&
    cmdOp <= `CAB_OP_FRACTIONAL_PRODUCT_MIXED |=> busy ##1 done && !busy;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply not 2 cycles");
  property p_jmp;
    take && (cmdOp == `CAB_OP_RELATIVE_BRANCH ||
    cmdOp == `CAB_OP_POINTER_BRANCH) |=> busy ##1 done && !busy;
  endproperty
  a_jmp: assert property (p_jmp) else $error("branch not 2 cycles");
  property p_rel;
    take && cmdOp == `CAB_OP_RELATIVE_BRANCH |=> pcOut == relTarget;
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_call;
    take && (cmdOp == `CAB_OP_RELATIVE_SUBROUTINE_ENTRY ||
    cmdOp == `CAB_OP_POINTER_SUBROUTINE_ENTRY) |=> busy[*2] ##1 done;
  endproperty
  a_call: assert property (p_call) else $error("entry not 3 cycles");
  property p_ret;
    take && (cmdOp == `CAB_OP_SUBROUTINE_EXIT ||
    cmdOp == `CAB_OP_HANDLER_EXIT) |=> busy[*3] ##1 done && !busy;
  endproperty
  a_ret: assert property (p_ret) else $error("return not 4 cycles");
  property p_int;
    take && cmdOp == `CAB_OP_HANDLER_EXIT |=> globalIntEnable;
  endproperty
  a_int: assert property (p_int) else $error("handler exit kept I low");
  property p_abs;
    LARGE_VARIANT != 0 && take && cmdOp == `CAB_OP_ABSOLUTE_BRANCH
    |=> pcOut == absTarget && busy ##1 busy ##1 done;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute branch wrong");
  property p_skip;
    take && cmdOp == `CAB_OP_SKIP_IF_EQUAL |-> ##[1:3] done;
  endproperty
  a_skip: assert property (p_skip) else $error("skip too slow");
  c_mul: cover property (take && cmdOp == `CAB_OP_PRODUCT_SIGNED);
  c_call: cover property (take && cmdOp == `CAB_OP_POINTER_SUBROUTINE_ENTRY);
  c_ret: cover property (take && cmdOp == `CAB_OP_HANDLER_EXIT);
endmodule // cab_exec_unit_checker

bind cab_exec_unit cab_exec_unit_checker #(
  .LARGE_VARIANT(LARGE_VARIANT)
) u_chk (
  .clk(clk),
  .nrst(nrst),
  .cmdValid(cmdValid),
  .cmdOp(cmdOp),
  .cmdK(cmdK),
  .busy(busy),
  .done(done),
  .pcOut(pcOut),
  .globalIntEnable(globalIntEnable)
);

// ### test/cab_exec_unit_tb.sv
// self-checking bench for the execution unit
// assumes the shared map header and the bound checker
`timescale 1ns/1ps
`include "cab_exec_map.vh"
// ----
// bench
// ----
module cab_exec_unit_tb;
  reg clk, nrst, cmdValid, cmdNextTwoWords, regWr, regRd, rdSeen, ci;
  reg [5:0] cmdOp, regAddr, c;
  reg [4:0] cmdDst;
  reg [15:0] cmdK, seed, pc, ret, p, sa, sb, note;
  reg [16:0] w;
  reg [7:0] regWrData, a, b;
  reg [23:0] e;
  reg [15:0] notes[$];
  wire [7:0] regRdData;
  wire busy, done, illegal, globalIntEnable;
  wire [15:0] pcOut;
  integer errors, checks, cycles, i;
  cab_exec_unit dut (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdDst(cmdDst), .cmdSrc(5'h11), .cmdK(cmdK),
    .cmdNextTwoWords(cmdNextTwoWords), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .busy(busy), .done(done), .illegal(illegal),
    .pcOut(pcOut), .globalIntEnable(globalIntEnable));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] sx(input [11:0] k);
    sx = {{4{k[11]}}, k};
  endfunction
  // {flag mask, flags, result}; flags are Z at bit 1, C at bit 0
  function [23:0] exp_alu(input [5:0] op, input [7:0] x, input [7:0] y,
      input cy);
    reg [8:0] r;
    reg [7:0] m;
    begin
      m = 8'h03;
      case (op)
        `CAB_OP_SUM: r = x + y;
        `CAB_OP_SUM_CARRY: r = x + y + cy;
        `CAB_OP_DIFFERENCE, `CAB_OP_DIFFERENCE_WITH_CONSTANT,
        `CAB_OP_REGISTER_COMPARISON: r = {1'b0, x} - y;
        `CAB_OP_CONJUNCTION, `CAB_OP_CONJUNCTION_WITH_CONST: r = {cy, x & y};
        `CAB_OP_DISJUNCTION, `CAB_OP_DISJUNCTION_WITH_CONST,
        `CAB_OP_BIT_SET_BY_MASK: r = {cy, x | y};
        `CAB_OP_EXCLUSIVE_DISJUNCTION: r = {cy, x ^ y};
        `CAB_OP_ONES_INVERSE: r = {1'b1, ~x};
        `CAB_OP_TWOS_INVERSE: r = 9'h000 - x;
        `CAB_OP_BIT_CLEAR_BY_MASK: r = {cy, x & ~y};
        `CAB_OP_PLUS_ONE: r = {cy, x + 8'h01};
        `CAB_OP_MINUS_ONE: r = {cy, x - 8'h01};
        `CAB_OP_REGISTER_ZEROING: r = {cy, 8'h00};
        `CAB_OP_REGISTER_ALL_ONES: r = {cy, 8'hff};
        default: r = {cy, x};
      endcase
      // borrow forms keep a sticky zero, so only carry is compared
      if (op == `CAB_OP_BORROW_DIFFERENCE ||
          op == `CAB_OP_BORROW_DIFFERENCE_CONST ||
          op == `CAB_OP_COMPARISON_WITH_BORROW) begin
        r = {1'b0, x} - y - cy;
        m = 8'h01;
      end
      exp_alu = {m, 6'h00, r[7:0] == 8'h00, r[8], r[7:0]};
      if (op == `CAB_OP_REGISTER_COMPARISON ||
          op == `CAB_OP_COMPARISON_WITH_BORROW)
        exp_alu[7:0] = x;
    end
  endfunction
  task cmp(input [7:0] got, input [7:0] want);
    begin
      checks = checks + 1;
      if (got !== want) begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task wr(input [5:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [5:0] ad, input [7:0] m, input [7:0] v);
    begin
      notes.push_back({m, v});
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge clk);
      regRd <= 1'b0;
    end
  endtask
  task op(input [5:0] code, input [4:0] d, input [15:0] k, input two);
    integer n;
    begin
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdOp <= code;
      cmdDst <= d;
      cmdK <= k;
      cmdNextTwoWords <= two;
      @(posedge clk);
      cmdValid <= 1'b0;
      n = 0;
      #1;
      while (done !== 1'b1 && n < 8) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      cmp({6'h00, illegal, done},
        {6'h00, code > `CAB_OP_COMPARISON_WITH_BORROW, 1'b1});
    end
  endtask
  task chk_pc;
    begin
      rd(`CAB_ADDR_PC_LOW, 8'hff, pc[7:0]);
      rd(`CAB_ADDR_PC_HIGH, 8'hff, pc[15:8]);
    end
  endtask
  // read data stand one cycle after the read strobe
  always @(posedge clk) begin
    rdSeen <= regRd;
    if (rdSeen) begin
      note = notes.pop_front();
      cmp(regRdData & note[15:8], note[7:0]);
    end
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {nrst, cmdValid, cmdNextTwoWords, regWr, regRd, rdSeen} = 6'h00;
    {cmdOp, regAddr, cmdDst, cmdK, regWrData} = 41'h0;
    seed = 16'd38207;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 24; i = i + 1) begin
      seed = lfsr(seed);
      {b, a} = seed;
      ci = seed[5] ^ seed[9];
      c = (i < 22) ? i[5:0] : i[5:0] + 6'h0f;
      if (c != `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE &&
          c != `CAB_OP_WORD_PAIR_MINUS_IMMEDIATE) begin
        wr(6'h10, a);
        wr(6'h11, b);
        wr(`CAB_ADDR_STATUS, {7'h00, ci});
        op(c, 5'h10, {8'h00, b}, 1'b0);
        e = exp_alu(c, a, b, ci);
        rd(6'h10, 8'hff, e[7:0]);
        rd(`CAB_ADDR_STATUS, e[23:16], e[15:8]);
      end
    end
    for (i = 0; i < 2; i = i + 1) begin
      seed = lfsr(seed);
      wr(6'h18, seed[7:0]);
      wr(6'h19, seed[15:8]);
      op(i ? `CAB_OP_WORD_PAIR_MINUS_IMMEDIATE :
        `CAB_OP_WORD_PAIR_PLUS_IMMEDIATE, 5'h18, {10'h000, seed[13:8]}, 1'b0);
      w = i ? {1'b0, seed} - seed[13:8] : {1'b0, seed} + seed[13:8];
      rd(6'h18, 8'hff, w[7:0]);
      rd(6'h19, 8'hff, w[15:8]);
      rd(`CAB_ADDR_STATUS, 8'h01, {7'h00, w[16]});
    end
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      {b, a} = seed;
      c = `CAB_OP_PRODUCT_UNSIGNED + i[5:0];
      wr(6'h10, a);
      wr(6'h11, b);
      op(c, 5'h10, 16'h0000, 1'b0);
      sa = (c == `CAB_OP_PRODUCT_UNSIGNED ||
        c == `CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED) ? {8'h00, a} : {{8{a[7]}}, a};
      sb = (c == `CAB_OP_PRODUCT_SIGNED ||
        c == `CAB_OP_FRACTIONAL_PRODUCT_SIGNED) ? {{8{b[7]}}, b} : {8'h00, b};
      p = sa * sb;
      ci = p[15];
      if (c >= `CAB_OP_FRACTIONAL_PRODUCT_UNSIGNED)
        p = p << 1;
      rd(6'h00, 8'hff, p[7:0]);
      rd(6'h01, 8'hff, p[15:8]);
      rd(`CAB_ADDR_STATUS, 8'h03, {6'h00, p == 16'h0000, ci});
    end
    pc = lfsr(seed);
    wr(`CAB_ADDR_PC_LOW, pc[7:0]);
    wr(`CAB_ADDR_PC_HIGH, pc[15:8]);
    op(`CAB_OP_RELATIVE_BRANCH, 5'h00, 16'h0800, 1'b0);
    pc = pc + 16'hf801;
    chk_pc;
    ret = pc + 16'h0001;
    op(`CAB_OP_RELATIVE_SUBROUTINE_ENTRY, 5'h00, {4'h0, seed[11:0]}, 1'b0);
    pc = pc + sx(seed[11:0]) + 16'h0001;
    chk_pc;
    rd(`CAB_ADDR_STACK, 8'hff, 8'h01);
    op(`CAB_OP_SUBROUTINE_EXIT, 5'h00, 16'h0000, 1'b0);
    pc = ret;
    chk_pc;
    rd(`CAB_ADDR_STACK, 8'hff, 8'h00);
    wr(6'h1e, seed[7:0]);
    wr(6'h1f, seed[15:8]);
    op(`CAB_OP_POINTER_BRANCH, 5'h00, 16'h0000, 1'b0);
    pc = seed;
    chk_pc;
    ret = pc + 16'h0001;
    op(`CAB_OP_POINTER_SUBROUTINE_ENTRY, 5'h00, 16'h0000, 1'b0);
    chk_pc;
    op(`CAB_OP_HANDLER_EXIT, 5'h00, 16'h0000, 1'b0);
    pc = ret;
    chk_pc;
    rd(`CAB_ADDR_STATUS, 8'h80, 8'h80);
    ret = pc + 16'h0002;
    op(`CAB_OP_ABSOLUTE_SUBROUTINE_ENTRY, 5'h00, ~seed, 1'b0);
    pc = ~seed;
    chk_pc;
    op(`CAB_OP_SUBROUTINE_EXIT, 5'h00, 16'h0000, 1'b0);
    pc = ret;
    chk_pc;
    op(`CAB_OP_ABSOLUTE_BRANCH, 5'h00, seed, 1'b0);
    pc = seed;
    chk_pc;
    for (i = 0; i < 3; i = i + 1) begin
      wr(6'h10, a);
      wr(6'h11, (i == 2) ? ~a : a);
      op(`CAB_OP_SKIP_IF_EQUAL, 5'h10, 16'h0000, i[0]);
      pc = pc + ((i == 2) ? 16'h0001 : 16'h0002 + {15'h0000, i[0]});
      chk_pc;
    end
    // unknown op leaves pc alone; unmapped address reads zero
    op(6'h3f, 5'h00, 16'h0000, 1'b0);
    chk_pc;
    rd(6'h3f, 8'hff, 8'h00);
    repeat (4) @(posedge clk);
    print_verdict;
  end
endmodule // cab_exec_unit_tb
